// *** hw/gpio_change_pkg.sv ***
// Constants, register map and carrier types for the three-port GPIO block.
// Assumes an AHB-Lite master with 32-bit whole-word single transfers.
package gpio_change_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] SECOND_PORT_DATA_IDX      = 8'h06;
  localparam logic [7:0] THIRD_PORT_DATA_IDX       = 8'h07;
  localparam logic [7:0] FOURTH_PORT_DATA_IDX      = 8'h08;
  localparam logic [7:0] INTERRUPT_CONTROL_IDX     = 8'h0B;
  localparam logic [7:0] OPTION_CONFIG_IDX         = 8'h81;
  localparam logic [7:0] SECOND_PORT_DIRECTION_IDX = 8'h86;
  localparam logic [7:0] THIRD_PORT_DIRECTION_IDX  = 8'h87;
  localparam logic [7:0] FOURTH_PORT_DIRECTION_IDX = 8'h88;
  localparam logic [7:0] FIFTH_PORT_DIRECTION_IDX  = 8'h89;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PULLUP_DISABLE_N_BIT   = 7;
  localparam int EXT_IRQ_EDGE_BIT       = 6;
  localparam int PORT_CHANGE_FLAG_BIT   = 0;
  localparam int EXT_IRQ_FLAG_BIT       = 1;
  localparam int SLAVE_MODE_ENABLE_BIT  = 4;
  localparam int SLAVE_RD_PIN           = 0;
  localparam int SLAVE_WR_PIN           = 1;
  localparam int SLAVE_CS_PIN           = 2;
  localparam int EXT_IRQ_PIN            = 0;

  // Writable bits of the fifth port direction register
  localparam logic [7:0] FIFTH_DIR_WR_MASK = 8'h17;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PORT_DATA_RESET      = 8'h00;
  localparam logic [7:0] OPTION_CONFIG_RESET  = 8'hFF;
  localparam logic [7:0] PORT_DIR_RESET       = 8'hFF;
  localparam logic [7:0] FIFTH_DIR_RESET      = 8'h07;

  // ****************************************************************
  // Bus phase tracking, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_READ  = 3'b010,
    PH_WRITE = 3'b100
  } phase_type;

  // One eight-bit port as seen at the pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } port_drive_type;

endpackage

// *** hw/gpio_change_top.sv ***
// Three 8-bit GPIO ports with change detection, external interrupt edge,
// peripheral direction overrides and parallel slave mode entry.
// Assumes all pin inputs are synchronous-capable levels on i_sys_clk and
// the AHB-Lite master issues only single whole-word transfers.
//
// Operation
// - Direction bit set tri-states, clear drives latch
// - Pull-up disable bit clear enables pull-ups
// - Output pins never get a pull-up
// - Reset leaves pull-ups disabled
// - Upper pins compared with copy from last read or write
// - Output pins excluded from change compare
// - Mismatches ORed set change flag
// - Change flag wakes device from sleep
// - Second port access refreshes compare copy
// - Mismatch keeps setting flag; read then clear
// - Pin zero is edge-selectable external interrupt
// - Third port pins individually direction settable
// - Third port pins shared with peripherals
// - Enabled peripheral overrides third port direction
// - Fourth port eight pins, own directions
// - Slave mode bit turns fourth port slave
// - Read returns pins, write updates latch
// - Fifth port low pins are slave strobes
`timescale 1ns/1ps
`default_nettype none

module gpio_change_top
  import gpio_change_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Second port pins
  input  wire logic [7:0]  i_b_pin,
  output logic      [7:0]  o_b_out,
  output logic      [7:0]  o_b_oe,
  output logic      [7:0]  o_b_pullup,
  // Third port pins and peripheral overrides
  input  wire logic [7:0]  i_c_pin,
  input  wire logic [7:0]  i_c_periph_en,
  input  wire logic [7:0]  i_c_periph_dir,
  input  wire logic [7:0]  i_c_periph_out,
  output logic      [7:0]  o_c_out,
  output logic      [7:0]  o_c_oe,
  // Fourth port pins
  input  wire logic [7:0]  i_d_pin,
  output logic      [7:0]  o_d_out,
  output logic      [7:0]  o_d_oe,
  // Fifth port low pins (slave strobes, active low)
  input  wire logic [2:0]  i_e_pin,
  // Status toward the core
  output logic             o_port_change_flag,
  output logic             o_ext_irq_flag,
  output logic             o_wake,
  output logic             o_slave_mode
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    phase_type      phase;       // Bus data phase in flight
    logic [7:0]     idx;         // Captured register index
    logic           mapped;      // Captured address is in range
    logic [31:0]    rdata;       // Read data register
    logic           readyout;    // Ready toward the bus
    logic [7:0]     b_latch;     // Second port output latch
    logic [7:0]     c_latch;     // Third port output latch
    logic [7:0]     d_latch;     // Fourth port output latch
    logic [7:0]     b_dir;       // Second port direction
    logic [7:0]     c_dir;       // Third port direction
    logic [7:0]     d_dir;       // Fourth port direction
    logic [7:0]     e_dir;       // Fifth port direction and slave mode
    logic [7:0]     option;      // Option configuration
    logic [7:0]     b_meta;      // First synchroniser stages
    logic [7:0]     c_meta;
    logic [7:0]     d_meta;
    logic [2:0]     e_meta;
    logic [7:0]     b_sync;      // Second synchroniser stages
    logic [7:0]     c_sync;
    logic [7:0]     d_sync;
    logic [2:0]     e_sync;
    logic           int0_prev;   // Previous external interrupt level
    logic [3:0]     cmp_copy;    // Upper-pin copy from last access
    logic           chg_flag;    // Port change flag
    logic           ext_flag;    // External interrupt flag
    port_drive_type b_drv;       // Registered pin drive
    port_drive_type c_drv;
    port_drive_type d_drv;
    logic [7:0]     b_pull;      // Registered pull-up enables
    logic           wake;        // Registered wake request
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************
  logic        addr_take;        // Valid address phase this cycle
  logic [7:0]  addr_idx;         // Index from byte address
  logic        addr_mapped;      // Index hits a register
  logic        wr_commit;        // Write data committed in the wait-state cycle
  logic [7:0]  wbyte;            // Low byte of write data
  logic [3:0]  mismatch;         // Per-pin change mismatch
  logic        b_access;         // Second port data touched
  logic        int0_edge;        // Selected edge on interrupt pin
  logic [7:0]  c_dir_eff;        // Third port direction after overrides
  logic        slave_on;         // Parallel slave mode active
  logic [7:0]  rd_value;         // Value for a read

  // ****************************************************************
  // Index decode
  // ****************************************************************
  function automatic logic idx_valid(input logic [7:0] idx);
    case (idx)
      SECOND_PORT_DATA_IDX, THIRD_PORT_DATA_IDX, FOURTH_PORT_DATA_IDX,
      INTERRUPT_CONTROL_IDX, OPTION_CONFIG_IDX,
      SECOND_PORT_DIRECTION_IDX, THIRD_PORT_DIRECTION_IDX,
      FOURTH_PORT_DIRECTION_IDX, FIFTH_PORT_DIRECTION_IDX: idx_valid = 1'b1;
      default: idx_valid = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_next  = state_reg;
    addr_take   = i_hsel & i_htrans[1] & i_hready;
    addr_idx    = i_haddr[9:2];
    addr_mapped = (i_haddr[31:10] == 22'h000000) &&
                  (i_haddr[1:0] == 2'h0) && idx_valid(addr_idx);
    wr_commit   = (state_reg.phase == PH_WRITE) && state_reg.mapped;
    wbyte       = i_hwdata[7:0];
    slave_on    = state_reg.e_dir[SLAVE_MODE_ENABLE_BIT];

    // Input synchronisers, first stage read only by second
    state_next.b_meta = i_b_pin;
    state_next.c_meta = i_c_pin;
    state_next.d_meta = i_d_pin;
    state_next.e_meta = i_e_pin;
    state_next.b_sync = state_reg.b_meta;
    state_next.c_sync = state_reg.c_meta;
    state_next.d_sync = state_reg.d_meta;
    state_next.e_sync = state_reg.e_meta;

    // Peripheral direction override on the third port
    c_dir_eff = (i_c_periph_en & i_c_periph_dir) |
                (~i_c_periph_en & state_reg.c_dir);

    // Read value: pins for data registers, effective third port direction, stored state otherwise
    case (addr_idx)
      SECOND_PORT_DATA_IDX:      rd_value = state_reg.b_sync;
      THIRD_PORT_DATA_IDX:       rd_value = state_reg.c_sync;
      FOURTH_PORT_DATA_IDX:      rd_value = state_reg.d_sync;
      INTERRUPT_CONTROL_IDX: begin
        rd_value = 8'h00;
        rd_value[PORT_CHANGE_FLAG_BIT] = state_reg.chg_flag;
        rd_value[EXT_IRQ_FLAG_BIT]     = state_reg.ext_flag;
      end
      OPTION_CONFIG_IDX:         rd_value = state_reg.option;
      SECOND_PORT_DIRECTION_IDX: rd_value = state_reg.b_dir;
      THIRD_PORT_DIRECTION_IDX:  rd_value = c_dir_eff;
      FOURTH_PORT_DIRECTION_IDX: rd_value = state_reg.d_dir;
      FIFTH_PORT_DIRECTION_IDX:  rd_value = state_reg.e_dir;
      default:                   rd_value = 8'h00;
    endcase

    // Bus phase tracking
    state_next.readyout = 1'b1;
    case (state_reg.phase)
      PH_WRITE: begin
        // Write data taken now; slave was not ready this cycle
        state_next.phase = PH_IDLE;
      end
      PH_IDLE, PH_READ: begin
        if (addr_take) begin
          state_next.idx    = addr_idx;
          state_next.mapped = addr_mapped;
          if (i_hwrite) begin
            // One wait state so the write lands before any read
            state_next.phase    = PH_WRITE;
            state_next.readyout = 1'b0;
          end else begin
            state_next.phase = PH_READ;
            state_next.rdata = addr_mapped ? {24'h000000, rd_value}
                                           : 32'h00000000;
          end
        end else begin
          state_next.phase = PH_IDLE;
        end
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase

    // Register writes
    if (wr_commit) begin
      case (state_reg.idx)
        SECOND_PORT_DATA_IDX:      state_next.b_latch = wbyte;
        THIRD_PORT_DATA_IDX:       state_next.c_latch = wbyte;
        FOURTH_PORT_DATA_IDX:      state_next.d_latch = wbyte;
        OPTION_CONFIG_IDX:         state_next.option  = wbyte;
        SECOND_PORT_DIRECTION_IDX: state_next.b_dir   = wbyte;
        THIRD_PORT_DIRECTION_IDX:  state_next.c_dir   = wbyte;
        FOURTH_PORT_DIRECTION_IDX: state_next.d_dir   = wbyte;
        FIFTH_PORT_DIRECTION_IDX:
          state_next.e_dir = wbyte & FIFTH_DIR_WR_MASK;
        default: ;
      endcase
    end

    // Change detection on the upper four pins
    mismatch = (state_reg.b_sync[7:4] ^ state_reg.cmp_copy) &
               state_reg.b_dir[7:4];
    b_access = (addr_take && addr_mapped && !i_hwrite &&
                addr_idx == SECOND_PORT_DATA_IDX) ||
               (wr_commit && state_reg.idx == SECOND_PORT_DATA_IDX);
    if (b_access) begin
      state_next.cmp_copy = state_reg.b_sync[7:4];
    end

    // External interrupt edge, rising when edge bit set
    state_next.int0_prev = state_reg.b_sync[EXT_IRQ_PIN];
    int0_edge = state_reg.option[EXT_IRQ_EDGE_BIT]
      ? ( state_reg.b_sync[EXT_IRQ_PIN] & ~state_reg.int0_prev)
      : (~state_reg.b_sync[EXT_IRQ_PIN] &  state_reg.int0_prev);

    // Sticky flags: software writes, hardware set wins
    if (wr_commit && state_reg.idx == INTERRUPT_CONTROL_IDX) begin
      state_next.chg_flag = wbyte[PORT_CHANGE_FLAG_BIT];
      state_next.ext_flag = wbyte[EXT_IRQ_FLAG_BIT];
    end
    if (|mismatch) begin
      state_next.chg_flag = 1'b1;
    end
    if (int0_edge) begin
      state_next.ext_flag = 1'b1;
    end

    // Second port drive and pull-ups
    state_next.b_drv.out = state_next.b_latch;
    state_next.b_drv.oe  = ~state_next.b_dir;
    state_next.b_pull    = {8{~state_next.option[PULLUP_DISABLE_N_BIT]}} &
                           state_next.b_dir;

    // Third port drive, peripheral owns enabled pins
    state_next.c_drv.out = (i_c_periph_en & i_c_periph_out) |
                           (~i_c_periph_en & state_next.c_latch);
    state_next.c_drv.oe  = ~((i_c_periph_en & i_c_periph_dir) |
                             (~i_c_periph_en & state_next.c_dir));

    // Fourth port drive; in slave mode the external strobes steer it
    state_next.d_drv.out = state_next.d_latch;
    if (state_next.e_dir[SLAVE_MODE_ENABLE_BIT]) begin
      state_next.d_drv.oe = {8{~state_reg.e_sync[SLAVE_CS_PIN] &
                               ~state_reg.e_sync[SLAVE_RD_PIN]}};
    end else begin
      state_next.d_drv.oe = ~state_next.d_dir;
    end

    // Wake request follows the change flag
    state_next.wake = state_next.chg_flag;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg          <= '0;
      state_reg.phase    <= PH_IDLE;
      state_reg.readyout <= 1'b1;
      state_reg.b_latch  <= PORT_DATA_RESET;
      state_reg.c_latch  <= PORT_DATA_RESET;
      state_reg.d_latch  <= PORT_DATA_RESET;
      state_reg.b_dir    <= PORT_DIR_RESET;
      state_reg.c_dir    <= PORT_DIR_RESET;
      state_reg.d_dir    <= PORT_DIR_RESET;
      state_reg.e_dir    <= FIFTH_DIR_RESET;
      state_reg.option   <= OPTION_CONFIG_RESET;
      state_reg.b_meta    <= state_next.b_meta;   // Keep tracking pins
      state_reg.b_sync    <= state_next.b_sync;   // so an idle-high pin
      state_reg.int0_prev <= state_next.int0_prev; // fakes no edge
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs, from flops except the tied-off response
  // ****************************************************************
  assign o_hrdata           = state_reg.rdata;
  assign o_hreadyout        = state_reg.readyout;
  assign o_hresp            = 1'b0;
  assign o_b_out            = state_reg.b_drv.out;
  assign o_b_oe             = state_reg.b_drv.oe;
  assign o_b_pullup         = state_reg.b_pull;
  assign o_c_out            = state_reg.c_drv.out;
  assign o_c_oe             = state_reg.c_drv.oe;
  assign o_d_out            = state_reg.d_drv.out;
  assign o_d_oe             = state_reg.d_drv.oe;
  assign o_port_change_flag = state_reg.chg_flag;
  assign o_ext_irq_flag     = state_reg.ext_flag;
  assign o_wake             = state_reg.wake;
  assign o_slave_mode       = state_reg.e_dir[SLAVE_MODE_ENABLE_BIT];

endmodule

`default_nettype wire

// *** bench/gpio_change_props.sv ***
// Checker for the three-port GPIO block, bound onto its top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module gpio_change_props (
  input wire logic       i_sys_clk,
  input wire logic       i_srst,
  input wire logic       i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic       i_hwrite,
  input wire logic       i_hready,
  input wire logic       o_hreadyout,
  input wire logic       o_hresp,
  input wire logic [7:0] i_b_pin,
  input wire logic [7:0] o_b_oe,
  input wire logic [7:0] o_b_pullup,
  input wire logic [7:0] i_c_periph_en,
  input wire logic [7:0] i_c_periph_dir,
  input wire logic [7:0] o_c_oe,
  input wire logic [2:0] i_e_pin,
  input wire logic [7:0] o_d_oe,
  input wire logic       o_port_change_flag,
  input wire logic       o_ext_irq_flag,
  input wire logic       o_wake,
  input wire logic       o_slave_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ****
  // Helper counters of recent causes
  // ****
  logic [7:0] prev_pin; // Pin levels one cycle back
  logic [3:0] since_wr; // Cycles since a write wait state
  logic [3:0] since_b0; // Cycles since pin 0 moved
  logic [3:0] since_hi; // Cycles since an upper input moved
  function automatic logic [3:0] bump(input logic clr, input logic [3:0] c);
    return clr ? 4'h0 : ((c == 4'hF) ? c : c + 4'h1);
  endfunction
  // Saturating counters, cleared by their cause
  always_ff @(posedge i_sys_clk) begin
    prev_pin <= i_b_pin;
    since_wr <= bump(i_srst || !o_hreadyout, since_wr);
    since_b0 <= bump(i_srst || (i_b_pin[0] ^ prev_pin[0]), since_b0);
    since_hi <= bump(i_srst || |((i_b_pin[7:4] ^ prev_pin[7:4])
                & ~o_b_oe[7:4]), since_hi);
  end
  // ****
  // Properties
  // ****
  sequence s_wr_taken;
    i_hsel && i_htrans[1] && i_hready && i_hwrite;
  endsequence
  sequence s_one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  property p_okay; o_hresp == 1'b0; endproperty
  property p_rd_fast;
    i_hsel && i_htrans[1] && i_hready && !i_hwrite |=> o_hreadyout;
  endproperty
  property p_wr_wait; s_wr_taken |=> s_one_wait; endproperty
  property p_pull_out; (o_b_pullup & o_b_oe) == 8'h00; endproperty
  property p_pull_all;
    o_b_pullup == 8'h00 || o_b_pullup == ~o_b_oe;
  endproperty
  property p_reset_pull;
    $fell(i_srst) |-> o_b_pullup == 8'h00 && o_b_oe == 8'h00;
  endproperty
  property p_wake; o_wake == o_port_change_flag; endproperty
  property p_sticky; $fell(o_port_change_flag) |-> $past(!o_hreadyout);
  endproperty
  property p_change_cause;
    $rose(o_port_change_flag) |-> since_hi < 4'h8 || since_wr < 4'h8;
  endproperty
  property p_ext_cause;
    $rose(o_ext_irq_flag) |-> since_b0 < 4'h8 || since_wr < 4'h8;
  endproperty
  property p_override;
    (o_c_oe & $past(i_c_periph_en)) ==
      ($past(i_c_periph_en) & ~$past(i_c_periph_dir));
  endproperty
  property p_slave_idle;
    i_e_pin[2] [*5] ##0 o_slave_mode |-> o_d_oe == 8'h00;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not okay");
  a_rd_fast: assert property (p_rd_fast)
    else $error("read took a wait state");
  a_wr_wait: assert property (p_wr_wait)
    else $error("write wait state wrong");
  a_pull_out: assert property (p_pull_out)
    else $error("pull-up on a driven pin");
  a_pull_all: assert property (p_pull_all)
    else $error("pull-ups not switched together");
  a_reset_pull: assert property (p_reset_pull)
    else $error("pins not idle after reset");
  a_wake: assert property (p_wake)
    else $error("wake differs from change flag");
  a_sticky: assert property (p_sticky)
    else $error("change flag fell without a write");
  a_change_cause: assert property (p_change_cause)
    else $error("change flag rose without cause");
  a_ext_cause: assert property (p_ext_cause)
    else $error("edge flag rose without cause");
  a_override: assert property (p_override)
    else $error("peripheral direction not applied");
  a_slave_idle: assert property (p_slave_idle)
    else $error("slave port drives while deselected");
endmodule
bind gpio_change_top gpio_change_props i_props (
  .i_sys_clk, .i_srst, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
  .o_hreadyout, .o_hresp, .i_b_pin, .o_b_oe, .o_b_pullup,
  .i_c_periph_en, .i_c_periph_dir, .o_c_oe, .i_e_pin, .o_d_oe,
  .o_port_change_flag, .o_ext_irq_flag, .o_wake, .o_slave_mode);
`default_nettype wire

// *** bench/keypad_model.sv ***
// Board model of keys and wiring on the second port pins.
// Assumes drive, enable and pull-up come from the block's registers.
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_out,     // Block drive value
  input  wire logic [7:0] i_oe,      // Block drives the pin
  input  wire logic [7:0] i_pullup,  // Weak pull-up on
  input  wire logic [7:0] i_key_en,  // Key or board drives the pin
  input  wire logic [7:0] i_key_val, // Key drive value
  output logic      [7:0] o_level    // Resolved wire level
);
  logic [7:0] float_reg = 8'h00;     // Level of a pin nobody drives
  wire  [7:0] drv = (i_oe | i_key_en | i_pullup) & {8{!$isunknown(i_oe)}};
  // Wire resolution: block, then key, then pull-up
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (i_oe[k]) o_level[k] = i_out[k];
      else if (i_key_en[k]) o_level[k] = i_key_val[k];
      else if (i_pullup[k]) o_level[k] = 1'b1;
      else o_level[k] = float_reg[k];
    end
  end
  // A released pin drifts to the inverse of its last level
  always_ff @(posedge i_sys_clk) begin
    float_reg <= (float_reg & ~drv) | (~o_level & drv);
  end
endmodule
`default_nettype wire

// *** bench/gpio_change_top_tb_top.sv ***
// Self-checking bench for the three-port GPIO block.
// Assumes the key model on the second port and an AHB-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module gpio_change_top_tb_top
  import gpio_change_pkg::*;
;
  logic        i_sys_clk = 1'b0;
  logic        i_srst    = 1'b1;
  logic        i_hsel    = 1'b0;
  logic [31:0] i_haddr   = 32'h0;
  logic [1:0]  i_htrans  = 2'h0;
  logic        i_hwrite  = 1'b0;
  logic [2:0]  i_hsize   = 3'h2;
  logic [31:0] i_hwdata  = 32'h0;
  logic [7:0]  i_c_pin = 8'h00, i_c_periph_en = 8'h00;
  logic [7:0]  i_c_periph_dir = 8'h00, i_c_periph_out = 8'h00;
  logic [7:0]  i_d_pin = 8'h00, key_en = 8'h00, key_val = 8'h00;
  logic [2:0]  i_e_pin = 3'h7;
  logic [31:0] o_hrdata;
  logic        o_hreadyout, o_hresp, o_port_change_flag;
  logic        o_ext_irq_flag, o_wake, o_slave_mode;
  logic [7:0]  i_b_pin, o_b_out, o_b_oe, o_b_pullup;
  logic [7:0]  o_c_out, o_c_oe, o_d_out, o_d_oe;
  int          failures = 0;
  int          samples_checked = 0;
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_type;
  row_type rows [13] = '{
    '{1'b0, OPTION_CONFIG_IDX, 8'h00, 8'hFF},
    '{1'b0, SECOND_PORT_DIRECTION_IDX, 8'h00, 8'hFF},
    '{1'b0, THIRD_PORT_DIRECTION_IDX, 8'h00, 8'hFF},
    '{1'b0, FOURTH_PORT_DIRECTION_IDX, 8'h00, 8'hFF},
    '{1'b0, FIFTH_PORT_DIRECTION_IDX, 8'h00, 8'h07},
    '{1'b0, INTERRUPT_CONTROL_IDX, 8'h00, 8'h00},
    '{1'b1, OPTION_CONFIG_IDX, 8'h3C, 8'h3C},
    '{1'b1, SECOND_PORT_DIRECTION_IDX, 8'h5A, 8'h5A},
    '{1'b1, THIRD_PORT_DIRECTION_IDX, 8'hA5, 8'hA5},
    '{1'b1, FOURTH_PORT_DIRECTION_IDX, 8'h3C, 8'h3C},
    '{1'b1, FIFTH_PORT_DIRECTION_IDX, 8'hEF, 8'h07},
    '{1'b1, 8'h40, 8'h55, 8'h00},
    '{1'b1, INTERRUPT_CONTROL_IDX, 8'h03, 8'h03}};
  always #2.5 i_sys_clk = ~i_sys_clk;
  gpio_change_top i_dut (.i_sys_clk, .i_srst, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout),
    .o_hrdata, .o_hreadyout, .o_hresp, .i_b_pin, .o_b_out, .o_b_oe,
    .o_b_pullup, .i_c_pin, .i_c_periph_en, .i_c_periph_dir,
    .i_c_periph_out, .o_c_out, .o_c_oe, .i_d_pin, .o_d_out, .o_d_oe,
    .i_e_pin, .o_port_change_flag, .o_ext_irq_flag, .o_wake,
    .o_slave_mode);
  keypad_model i_keys (.i_sys_clk, .i_out(o_b_out), .i_oe(o_b_oe),
    .i_pullup(o_b_pullup), .i_key_en(key_en), .i_key_val(key_val),
    .o_level(i_b_pin));
  // ****
  // Report, compare and bus tasks
  // ****
  task automatic complete_run();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string name, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // Bounded wait for hready sampled high at an edge
  task automatic wait_ready();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      if (o_hreadyout === 1'b1) break;
    end
    if (n == 40) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, wd,
                     output logic [7:0] rd);
    @(posedge i_sys_clk);
    i_hsel   <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr  <= {22'h0, idx, 2'b00};
    i_hwrite <= w;
    wait_ready();
    i_htrans <= 2'b00;
    i_hwdata <= {24'h0, wd};
    wait_ready();
    rd = o_hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, wd);
    logic [7:0] v;
    bus(1'b1, idx, wd, v);
  endtask
  task automatic chk(input string name, input logic [7:0] idx, e);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    cmp(name, e, v);
  endtask
  task automatic run_rows(input int lo, hi);
    for (int r = lo; r < hi; r++) begin
      if (rows[r].wr) wr(rows[r].idx, rows[r].wd);
      chk("register", rows[r].idx, rows[r].exp);
    end
  endtask
  task automatic do_reset();
    i_srst <= 1'b1;
    wait_clk(20);
    i_srst <= 1'b0;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    @(posedge i_sys_clk);
    do_reset();
    run_rows(0, 13);
    cmp("pullup", 8'h5A, o_b_pullup);
    // Upper pins drive, lower pins pulled up
    wr(SECOND_PORT_DIRECTION_IDX, 8'h0F);
    wr(SECOND_PORT_DATA_IDX, 8'hA5);
    wr(OPTION_CONFIG_IDX, 8'h7F);
    wait_clk(4);
    cmp("b_oe", 8'hF0, o_b_oe);
    cmp("b_out", 8'hA0, o_b_out & o_b_oe);
    cmp("b_pullup", 8'h0F, o_b_pullup);
    chk("b_pins", SECOND_PORT_DATA_IDX, 8'hAF);
    // Key press on an upper input pin
    wr(SECOND_PORT_DIRECTION_IDX, 8'hFF);
    wait_clk(4);
    chk("b_pins", SECOND_PORT_DATA_IDX, 8'hFF);
    wr(INTERRUPT_CONTROL_IDX, 8'h00);
    cmp("flag", 8'h00, {7'h0, o_port_change_flag});
    key_en <= 8'h20;
    wait_clk(8);
    cmp("flag", 8'h01, {7'h0, o_port_change_flag});
    cmp("wake", 8'h01, {7'h0, o_wake});
    wr(INTERRUPT_CONTROL_IDX, 8'h00);
    cmp("flag", 8'h01, {7'h0, o_port_change_flag});
    chk("b_pins", SECOND_PORT_DATA_IDX, 8'hDF);
    wr(INTERRUPT_CONTROL_IDX, 8'h00);
    wait_clk(8);
    cmp("flag", 8'h00, {7'h0, o_port_change_flag});
    // Output pin toggling stays out of the compare
    wr(SECOND_PORT_DIRECTION_IDX, 8'hBF);
    chk("b_pins", SECOND_PORT_DATA_IDX, 8'h9F);
    wr(INTERRUPT_CONTROL_IDX, 8'h00);
    wr(SECOND_PORT_DATA_IDX, 8'hE5);
    wait_clk(8);
    cmp("flag", 8'h00, {7'h0, o_port_change_flag});
    // Both edge selections of pin zero
    key_en <= 8'h01;
    for (int e = 0; e < 2; e++) begin
      wr(OPTION_CONFIG_IDX, {1'b0, e[0], 6'h3F});
      key_val <= {7'h0, ~e[0]};
      wait_clk(6);
      wr(INTERRUPT_CONTROL_IDX, 8'h00);
      cmp("ext", 8'h00, {7'h0, o_ext_irq_flag});
      key_val <= {7'h0, e[0]};
      wait_clk(6);
      cmp("ext", 8'h01, {7'h0, o_ext_irq_flag});
      wr(INTERRUPT_CONTROL_IDX, 8'h00);
      key_val <= {7'h0, ~e[0]};
      wait_clk(6);
      cmp("ext", 8'h00, {7'h0, o_ext_irq_flag});
    end
    // Peripheral owns the low third port pins
    i_c_periph_en  <= 8'h0F;
    i_c_periph_dir <= 8'h0C;
    i_c_periph_out <= 8'h02;
    i_c_pin        <= 8'h3C;
    wait_clk(4);
    cmp("c_oe", 8'h53, o_c_oe);
    cmp("c_out", 8'h02, o_c_out & 8'h03);
    chk("c_dir", THIRD_PORT_DIRECTION_IDX, 8'hAC);
    chk("c_pins", THIRD_PORT_DATA_IDX, 8'h3C);
    i_c_periph_en <= 8'h00;
    // Fourth port, then parallel slave mode
    i_d_pin <= 8'h96;
    wr(FOURTH_PORT_DATA_IDX, 8'h5A);
    wait_clk(4);
    cmp("d_oe", 8'hC3, o_d_oe);
    cmp("d_out", 8'h42, o_d_out & o_d_oe);
    chk("d_pins", FOURTH_PORT_DATA_IDX, 8'h96);
    wr(FIFTH_PORT_DIRECTION_IDX, 8'h17);
    cmp("slave", 8'h01, {7'h0, o_slave_mode});
    i_e_pin <= 3'b010;
    wait_clk(5);
    cmp("d_oe", 8'hFF, o_d_oe);
    i_e_pin <= 3'b111;
    wait_clk(5);
    cmp("d_oe", 8'h00, o_d_oe);
    wr(FIFTH_PORT_DIRECTION_IDX, 8'h07);
    wait_clk(2);
    cmp("slave", 8'h00, {7'h0, o_slave_mode});
    cmp("d_oe", 8'hC3, o_d_oe);
    // Second reset in mid-run
    key_en  <= 8'hFF;
    key_val <= 8'h00;
    do_reset();
    run_rows(0, 6);
    cmp("pullup", 8'h00, o_b_pullup);
    complete_run();
  end
endmodule
`default_nettype wire
